// File: common/pte_cfg.svh
`ifndef PTE_CFG_SVH
`define PTE_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PTE_A_TEST_CTRL 8'h00
`define PTE_A_TEST_STAT 8'h04
`define PTE_A_SAT0 8'h08
`define PTE_A_MON_SRC0 8'h18
`define PTE_A_MON_VAL0 8'h20
`define PTE_A_PEAK 8'h28
`define PTE_A_PEAK_THR 8'h2C
`define PTE_A_LAST_IDX 8'h30
`define PTE_A_MAX_DESC 8'h34
`define PTE_A_DESC_SLOT 8'h38
`define PTE_A_DESC_INFO 8'h3C
`define PTE_A_DESC_VAL 8'h40
`define PTE_A_CNT_CLR 8'h44

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PTE_STAT_ACTIVE 0
`define PTE_STAT_PEND 1
`define PTE_STAT_REJECT 2
`define PTE_STAT_STOP 3
`define PTE_STAT_LRST 4
`define PTE_CLR_MON_LSB 4
`define PTE_CLR_PEAK 6

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define PTE_PHY_ID 4'h0
`define PTE_FN_STOP 8'h00
`define PTE_FN_TX_PATTERN 8'h01
`define PTE_SRC_NONE 8'h00
`define PTE_SRC_INVALID_DWORD 8'h01
`define PTE_SRC_RX_ERROR 8'h06
`define PTE_SRC_CONN_PEAK 8'h2B
`define PTE_IDX_FIRST 16'h0001
`define PTE_IDX_LAST 16'hFFFF
`define PTE_IDX_RESET 16'h0000
`define PTE_DESC_DEPTH 8
`define PTE_MON_SLOTS 2
`define PTE_SAT_COUNTERS 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PTE_CLK_MHZ 250
`define PTE_STOP_NS 40
`define PTE_STOP_CYC ((`PTE_STOP_NS * `PTE_CLK_MHZ + 999) / 1000)

`endif

// File: common/pte_pkg.sv
package pte_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PEND = 5'b00010,
    ST_ACTIVE = 5'b00100,
    ST_STOP = 5'b01000,
    ST_LRST = 5'b10000
  } pte_state_t;

  typedef struct packed {
    logic [6:0] rsvd;
    logic mgmtPath;
    logic [3:0] rxPhy;
    logic [3:0] targetPhy;
    logic [3:0] rate;
    logic [3:0] pattern;
    logic [7:0] func;
  } pte_test_cmd_t;

  typedef struct packed {
    logic rxError;
    logic elasticOvf;
    logic resetProblem;
    logic lossSync;
    logic disparityErr;
    logic invalidDword;
  } pte_phy_evt_t;

  typedef struct packed {
    logic cominit;
    logic comwake;
    logic comsas;
  } pte_oob_t;

  typedef struct packed {
    logic enable;
    logic [3:0] pattern;
    logic [3:0] rate;
  } pte_tx_ctrl_t;

  typedef struct packed {
    logic [15:0] index;
    logic [7:0] source;
    logic [31:0] value;
  } pte_desc_t;

endpackage

// File: rtl/pte_evt_counter.sv
`timescale 1ns/10ps
module pte_evt_counter #(
  parameter bit SATURATE = 1'b1
) (
  input wire logic clk, // clock
  input wire logic rst, // synchronous reset
  input wire logic inc, // count one event
  input wire logic clr, // clear to zero
  output logic [31:0] count // current count
);

  // A clear in the same cycle as an event keeps that event.
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 32'h0;
    end else if (clr) begin
      count <= {31'h0, inc};
    end else if (inc) begin
      if (!(SATURATE && (&count))) begin
        count <= count + 32'h1;
      end
    end
  end

endmodule

// File: rtl/pte_desc_mem.sv
`timescale 1ns/10ps
module pte_desc_mem (
  input wire logic clk, // clock
  input wire logic we, // write enable
  input wire logic [2:0] waddr, // write slot
  input wire pte_pkg::pte_desc_t wdata, // descriptor to store
  input wire logic [2:0] raddr, // read slot
  output pte_pkg::pte_desc_t rdata // registered read data
);
  import pte_pkg::*;

  pte_desc_t mem [0:7];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule

// File: rtl/pte_top.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
`include "pte_cfg.svh"

// Notes on behaviour
// - In slumber only COMINIT and COMWAKE act; received traffic is ignored.
// - A test request naming the receiving phy, or another phy, is refused.
// - Diagnostic path: test starts after RESPONSE frame ACK is seen.
// - Management path: test starts after the response frame is sent.
// - During a test incoming dwords are discarded; only COMINIT is heeded.
// - Test ends on stop code 00h, on COMINIT, or on power loss.
// - After a test ends the phy performs a link reset.
// - Pattern test ignores received dwords and repeats the pattern at rate.
// - Four saturating counters: invalid, disparity, sync loss, reset problem.
// - Each saturating counter is 32 bits wide.
// - Wrapping counters and the peak detector are 32 bits wide.
// - A peak above threshold raises an expander broadcast request; here a zero threshold raises none.
// - Software chooses which events the monitor slots count.
// - Descriptor indexes are given in sequence starting at 0001h.
// - The index of the newest descriptor is readable.
// - After the highest index the index wraps to 0001h.
// - Descriptor indexes span 0001h to FFFFh.
// - When the store is full the oldest descriptor is overwritten.
// - Eight descriptors are kept; that number is readable.
// - Each event value carries its event-type code.
// - Event-type code 00h means no event and an invalid value.
// - Event-type code 01h counts invalid dwords.
module pte_top (
  input wire logic clk, // 250 MHz phy clock
  input wire logic rst, // synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  input wire pte_pkg::pte_phy_evt_t phyEvt, // event strobes
  input wire pte_pkg::pte_oob_t oob, // detected OOB signals
  input wire logic slumber, // phy in slumber power condition
  input wire logic respAck, // ACK seen for diagnostic RESPONSE
  input wire logic respTxDone, // management response sent
  input wire logic [31:0] connTime, // finished connection time
  input wire logic connTimeValid, // connTime strobe
  input wire logic linkResetDone, // link reset sequence finished
  output logic rxDiscard, // drop all received dwords
  output logic comwakeAccept, // COMWAKE may be acted on
  output logic comsasAccept, // COMSAS may be acted on
  output pte_pkg::pte_tx_ctrl_t txCtrl, // pattern transmit control
  output logic linkResetReq, // request a link reset sequence
  output logic broadcastReq, // expander broadcast pulse
  output logic testActive // test function running
);
  import pte_pkg::*;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setup;
  logic addrOk;
  logic wrEn;
  logic [31:0] rdMux;

  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pready & pwrite & ~pslverr;

  // One wait-free answer: pready rises in the access cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addrOk;
      if (setup && !pwrite) begin
        prdata <= addrOk ? rdMux : 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Test function control
  // ----------------------------------------------------------------
  pte_state_t state_reg;
  pte_test_cmd_t cmd_reg;
  pte_test_cmd_t cmdIn;
  logic reject_reg;
  logic [7:0] stopCnt_reg;
  logic cmdWr;
  logic cmdOk;
  logic isStop;

  assign cmdIn = pte_test_cmd_t'(pwdata);
  assign cmdWr = wrEn && (paddr == `PTE_A_TEST_CTRL);
  assign cmdOk = (cmdIn.targetPhy == `PTE_PHY_ID) &&
                 (cmdIn.targetPhy != cmdIn.rxPhy);
  assign isStop = (cmdIn.func == `PTE_FN_STOP);

  always_ff @(posedge clk) begin
    if (rst) begin
      reject_reg <= 1'b0;
      cmd_reg <= '0;
    end else if (cmdWr) begin
      reject_reg <= ~cmdOk;
      if (cmdOk && (!isStop) && (state_reg == ST_IDLE)) begin
        cmd_reg <= cmdIn;
      end
    end
  end

  // Power loss is the reset itself, so it ends any test as well.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      stopCnt_reg <= 8'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cmdWr && cmdOk && !isStop) begin
            state_reg <= ST_PEND;
          end
        end
        ST_PEND: begin
          if ((cmdWr && cmdOk && isStop) || oob.cominit) begin
            state_reg <= ST_IDLE;
          end else if (cmd_reg.mgmtPath ? respTxDone : respAck) begin
            state_reg <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if ((cmdWr && cmdOk && isStop) || oob.cominit) begin
            state_reg <= ST_STOP;
            stopCnt_reg <= 8'(`PTE_STOP_CYC - 1);
          end
        end
        ST_STOP: begin
          if (stopCnt_reg == 8'h0) begin
            state_reg <= ST_LRST;
          end else begin
            stopCnt_reg <= stopCnt_reg - 8'h1;
          end
        end
        ST_LRST: begin
          if (linkResetDone) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link-facing outputs
  // ----------------------------------------------------------------
  logic inTest;

  assign inTest = (state_reg == ST_ACTIVE) || (state_reg == ST_STOP);

  // These follow the state by one cycle, so the first dword after the
  // test starts may still be passed to the link layer.
  always_ff @(posedge clk) begin
    if (rst) begin
      rxDiscard <= 1'b0;
      comwakeAccept <= 1'b1;
      comsasAccept <= 1'b1;
      testActive <= 1'b0;
      linkResetReq <= 1'b0;
      txCtrl <= '0;
    end else begin
      rxDiscard <= inTest | slumber;
      comwakeAccept <= ~inTest;
      comsasAccept <= ~inTest & ~slumber;
      testActive <= (state_reg == ST_ACTIVE);
      linkResetReq <= (state_reg == ST_LRST);
      txCtrl.enable <= (state_reg == ST_ACTIVE) &&
                       (cmd_reg.func == `PTE_FN_TX_PATTERN);
      txCtrl.pattern <= cmd_reg.pattern;
      txCtrl.rate <= cmd_reg.rate;
    end
  end

  // ----------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------
  logic [5:0] evtVec;
  logic [7:0] clrBits;
  logic [31:0] satCnt [0:`PTE_SAT_COUNTERS-1];
  logic [31:0] monCnt [0:`PTE_MON_SLOTS-1];
  logic [7:0] monSrc_reg [0:`PTE_MON_SLOTS-1];

  // Events seen while dwords are being discarded are not counted.
  assign evtVec = rxDiscard ? 6'h0 : phyEvt;
  assign clrBits = (wrEn && (paddr == `PTE_A_CNT_CLR)) ? pwdata[7:0] : 8'h0;

  function automatic logic evtSel(input logic [7:0] code,
                                  input logic [5:0] ev);
    evtSel = 1'b0;
    if ((code >= `PTE_SRC_INVALID_DWORD) && (code <= `PTE_SRC_RX_ERROR)) begin
      evtSel = ev[3'(code - `PTE_SRC_INVALID_DWORD)];
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `PTE_SAT_COUNTERS; gi++) begin : gSat
      pte_evt_counter #(.SATURATE(1'b1)) uSat (
        .clk(clk),
        .rst(rst),
        .inc(evtVec[gi]),
        .clr(clrBits[gi]),
        .count(satCnt[gi])
      );
    end
    for (gi = 0; gi < `PTE_MON_SLOTS; gi++) begin : gMon
      always_ff @(posedge clk) begin
        if (rst) begin
          monSrc_reg[gi] <= `PTE_SRC_NONE;
        end else if (wrEn && (paddr == `PTE_A_MON_SRC0 + 8'(4 * gi))) begin
          monSrc_reg[gi] <= pwdata[7:0];
        end
      end
      pte_evt_counter #(.SATURATE(1'b0)) uMon (
        .clk(clk),
        .rst(rst),
        .inc(evtSel(monSrc_reg[gi], evtVec)),
        .clr(clrBits[`PTE_CLR_MON_LSB + gi]),
        .count(monCnt[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Peak detector and descriptor list
  // ----------------------------------------------------------------
  logic [31:0] peak_reg;
  logic [31:0] peakThr_reg;
  logic peakHit;
  logic [15:0] lastIdx_reg;
  logic [2:0] wrSlot_reg;
  logic [3:0] stored_reg;
  logic [2:0] descSlot_reg;
  pte_desc_t descWr;
  pte_desc_t descRd;
  logic [15:0] nextIdx;

  // A zero threshold disables the broadcast.
  assign peakHit = connTimeValid && (connTime > peak_reg) &&
                   (peakThr_reg != 32'h0) && (connTime > peakThr_reg);
  assign nextIdx = (lastIdx_reg == `PTE_IDX_LAST || lastIdx_reg ==
                    `PTE_IDX_RESET) ? `PTE_IDX_FIRST
                                    : lastIdx_reg + 16'h1;
  assign descWr = '{index: nextIdx, source: `PTE_SRC_CONN_PEAK,
                    value: connTime};

  always_ff @(posedge clk) begin
    if (rst) begin
      peak_reg <= 32'h0;
    end else if (clrBits[`PTE_CLR_PEAK]) begin
      peak_reg <= connTimeValid ? connTime : 32'h0;
    end else if (connTimeValid && (connTime > peak_reg)) begin
      peak_reg <= connTime;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      broadcastReq <= 1'b0;
    end else begin
      broadcastReq <= peakHit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lastIdx_reg <= `PTE_IDX_RESET;
      wrSlot_reg <= 3'h0;
      stored_reg <= 4'h0;
    end else if (peakHit) begin
      lastIdx_reg <= nextIdx;
      wrSlot_reg <= wrSlot_reg + 3'h1;
      if (stored_reg != 4'(`PTE_DESC_DEPTH)) begin
        stored_reg <= stored_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      peakThr_reg <= 32'h0;
      descSlot_reg <= 3'h0;
    end else if (wrEn) begin
      if (paddr == `PTE_A_PEAK_THR) begin
        peakThr_reg <= pwdata;
      end
      if (paddr == `PTE_A_DESC_SLOT) begin
        descSlot_reg <= pwdata[2:0];
      end
    end
  end

  pte_desc_mem uMem (
    .clk(clk),
    .we(peakHit),
    .waddr(wrSlot_reg),
    .wdata(descWr),
    .raddr(descSlot_reg),
    .rdata(descRd)
  );

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  logic slotValid;

  assign slotValid = ({1'b0, descSlot_reg} < stored_reg);

  always_comb begin
    addrOk = 1'b1;
    rdMux = 32'h0;
    unique case (paddr)
      `PTE_A_TEST_CTRL: rdMux = cmd_reg;
      `PTE_A_TEST_STAT: begin
        rdMux[`PTE_STAT_ACTIVE] = (state_reg == ST_ACTIVE);
        rdMux[`PTE_STAT_PEND] = (state_reg == ST_PEND);
        rdMux[`PTE_STAT_REJECT] = reject_reg;
        rdMux[`PTE_STAT_STOP] = (state_reg == ST_STOP);
        rdMux[`PTE_STAT_LRST] = (state_reg == ST_LRST);
      end
      `PTE_A_SAT0: rdMux = satCnt[0];
      `PTE_A_SAT0 + 8'h4: rdMux = satCnt[1];
      `PTE_A_SAT0 + 8'h8: rdMux = satCnt[2];
      `PTE_A_SAT0 + 8'hC: rdMux = satCnt[3];
      `PTE_A_MON_SRC0: rdMux = {24'h0, monSrc_reg[0]};
      `PTE_A_MON_SRC0 + 8'h4: rdMux = {24'h0, monSrc_reg[1]};
      // Code 00h reports no event, so its value reads as zero.
      `PTE_A_MON_VAL0: begin
        rdMux = (monSrc_reg[0] == `PTE_SRC_NONE) ? 32'h0 : monCnt[0];
      end
      `PTE_A_MON_VAL0 + 8'h4: begin
        rdMux = (monSrc_reg[1] == `PTE_SRC_NONE) ? 32'h0 : monCnt[1];
      end
      `PTE_A_PEAK: rdMux = peak_reg;
      `PTE_A_PEAK_THR: rdMux = peakThr_reg;
      `PTE_A_LAST_IDX: rdMux = {16'h0, lastIdx_reg};
      `PTE_A_MAX_DESC: rdMux = 32'(`PTE_DESC_DEPTH);
      `PTE_A_DESC_SLOT: rdMux = {29'h0, descSlot_reg};
      `PTE_A_DESC_INFO: begin
        rdMux = slotValid ? {descRd.index, 8'h0, descRd.source} : 32'h0;
      end
      `PTE_A_DESC_VAL: rdMux = slotValid ? descRd.value : 32'h0;
      `PTE_A_CNT_CLR: rdMux = 32'h0;
      default: addrOk = 1'b0;
    endcase
  end

endmodule

// File: sim/pte_top_sva.sv
`timescale 1ns/10ps
module pte_top_sva (
  input wire logic clk, // phy clock
  input wire logic rst, // synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire pte_pkg::pte_oob_t oob, // OOB pulses
  input wire logic slumber, // slumber level
  input wire logic respAck, // diagnostic ACK
  input wire logic respTxDone, // management response sent
  input wire logic connTimeValid, // connection time strobe
  input wire logic rxDiscard, // receive discard
  input wire logic comwakeAccept, // COMWAKE gate
  input wire logic comsasAccept, // COMSAS gate
  input wire pte_pkg::pte_tx_ctrl_t txCtrl, // pattern control
  input wire logic linkResetReq, // link reset request
  input wire logic broadcastReq, // broadcast pulse
  input wire logic testActive // test running
);
  import pte_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_slumber_gate: assert property (slumber[*3] |-> !comsasAccept)
    else $error("COMSAS accepted in slumber");
  a_test_discard: assert property (testActive |-> rxDiscard)
    else $error("dwords kept during test");
  a_test_oob_gate: assert property (
    testActive |-> !comwakeAccept && !comsasAccept)
    else $error("OOB other than COMINIT accepted in test");
  a_pattern_tx: assert property (txCtrl.enable |-> testActive)
    else $error("pattern sent outside test");
  a_start_cause: assert property ($rose(testActive) |->
    $past(respAck, 2) || $past(respTxDone, 2))
    else $error("test started without response event");
  a_cominit_end: assert property (
    testActive && oob.cominit |-> ##2 !testActive)
    else $error("COMINIT did not end test");
  a_reset_follow: assert property (
    $fell(testActive) |-> ##[1:20] linkResetReq)
    else $error("no link reset after test");
  a_bcast_cause: assert property (broadcastReq |->
    $past(connTimeValid) || $past(connTimeValid, 2))
    else $error("broadcast without connection time");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
endmodule
bind pte_top pte_top_sva chkI (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .oob(oob), .slumber(slumber),
  .respAck(respAck), .respTxDone(respTxDone),
  .connTimeValid(connTimeValid), .rxDiscard(rxDiscard),
  .comwakeAccept(comwakeAccept), .comsasAccept(comsasAccept),
  .txCtrl(txCtrl), .linkResetReq(linkResetReq),
  .broadcastReq(broadcastReq), .testActive(testActive));

// File: sim/pte_link_partner.sv
`timescale 1ns/10ps
module pte_link_partner (
  input wire logic clk, // phy clock
  input wire logic rst, // synchronous reset
  input wire logic kick, // start the response event
  input wire logic mgmt, // management path when high
  input wire logic slow, // answer late when high
  input wire logic stopReq, // send COMINIT once
  input wire logic linkResetReq, // link reset in progress
  output pte_pkg::pte_oob_t oob, // OOB detections
  output logic respAck, // ACK for the response frame
  output logic respTxDone, // response frame sent
  output logic linkResetDone // link reset finished
);
  import pte_pkg::*;
  logic [3:0] rspCnt_reg;
  logic [3:0] lrCnt_reg;
  // --------------------------------------------------------------
  // Far side behaviour
  // --------------------------------------------------------------
  // Equipment never sends COMSAS or COMWAKE and COMINIT only to stop.
  always_ff @(posedge clk) begin
    if (rst) oob <= '0;
    else oob <= '{stopReq, 1'h0, 1'h0};
  end
  always_ff @(posedge clk) begin
    respAck <= 1'h0;
    respTxDone <= 1'h0;
    if (rst) rspCnt_reg <= 4'h0;
    else if (kick) rspCnt_reg <= slow ? 4'h9 : 4'h1;
    else if (rspCnt_reg != 4'h0) begin
      rspCnt_reg <= rspCnt_reg - 4'h1;
      respAck <= rspCnt_reg == 4'h1 && !mgmt;
      respTxDone <= rspCnt_reg == 4'h1 && mgmt;
    end
  end
  // The done pulse comes once per request; the counter parks at all ones.
  always_ff @(posedge clk) begin
    linkResetDone <= 1'h0;
    if (rst || !linkResetReq) lrCnt_reg <= 4'h0;
    else if (lrCnt_reg != 4'hF) begin
      lrCnt_reg <= lrCnt_reg + 4'h1;
      linkResetDone <= lrCnt_reg == (slow ? 4'hB : 4'h2);
    end
  end
endmodule

// File: sim/pte_top_tb.sv
`timescale 1ns/10ps
`include "pte_cfg.svh"
module pte_top_tb;
  import pte_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, respAck, respTxDone, linkResetDone, rxDiscard;
  logic comwakeAccept, comsasAccept, linkResetReq, broadcastReq, testActive;
  pte_phy_evt_t phyEvt = '0;
  pte_oob_t oob;
  pte_tx_ctrl_t txCtrl;
  logic slumber = 1'h0;
  logic [31:0] connTime = 32'h0;
  logic connTimeValid = 1'h0;
  logic kick = 1'h0;
  logic mgmt = 1'h0;
  logic slow = 1'h0;
  logic stopReq = 1'h0;
  logic [33:0] expQ[$];
  logic [33:0] e;
  int num_errors = 0;
  int checks = 0;
  int bcasts = 0;
  always #2 clk = ~clk;
  pte_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phyEvt(phyEvt), .oob(oob),
    .slumber(slumber), .respAck(respAck), .respTxDone(respTxDone),
    .connTime(connTime), .connTimeValid(connTimeValid),
    .linkResetDone(linkResetDone), .rxDiscard(rxDiscard),
    .comwakeAccept(comwakeAccept), .comsasAccept(comsasAccept),
    .txCtrl(txCtrl), .linkResetReq(linkResetReq),
    .broadcastReq(broadcastReq), .testActive(testActive));
  pte_link_partner partner (.clk(clk), .rst(rst), .kick(kick),
    .mgmt(mgmt), .slow(slow), .stopReq(stopReq),
    .linkResetReq(linkResetReq), .oob(oob), .respAck(respAck),
    .respTxDone(respTxDone), .linkResetDone(linkResetDone));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    $display("[ERR] %0t wait ran out", $time);
    complete_run();
  endtask
  // A read notes its data, every transfer notes its error flag.
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic err = 1'h0);
    int n;
    expQ.push_back({wr, err, d});
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) hang();
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready === 1'h1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (!e[33]) chk(prdata, e[31:0]);
    end
    if (broadcastReq === 1'h1) bcasts++;
  end
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      @(posedge clk);
      phyEvt <= pte_phy_evt_t'(6'h01 << b);
    end
    @(posedge clk);
    phyEvt <= '0;
  endtask
  task automatic waitOn(input bit lr, input logic v);
    int n;
    n = 0;
    while ((lr ? linkResetReq : testActive) !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n == 300) hang();
  endtask
  task automatic poke(input bit s);
    @(posedge clk);
    if (s) stopReq <= 1'h1;
    else kick <= 1'h1;
    @(posedge clk);
    stopReq <= 1'h0;
    kick <= 1'h0;
  endtask
  task automatic conns(input int from, input int cnt);
    for (int k = 0; k < cnt; k++) begin
      @(posedge clk);
      connTime <= 32'(from + k);
      connTimeValid <= 1'h1;
    end
    @(posedge clk);
    connTimeValid <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] cmdW(logic m, logic [3:0] rx, tg,
      logic [3:0] rt, pt, logic [7:0] f);
    pte_test_cmd_t c;
    c = '{7'h0, m, rx, tg, rt, pt, f};
    return c;
  endfunction
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    int n, m;
    logic [3:0] pt, rt;
    void'($urandom(50107));
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, `PTE_A_MAX_DESC, 32'h8);
    apb(1'h0, `PTE_A_LAST_IDX, 32'h0);
    apb(1'h0, 8'hFC, 32'h0, 1'h1);
    n = $urandom_range(20, 1);
    m = $urandom_range(20, 1);
    apb(1'h1, `PTE_A_MON_SRC0, 32'h1);
    apb(1'h1, `PTE_A_MON_SRC0 + 8'h4, 32'h0);
    pulse(0, n);
    pulse(1, m);
    apb(1'h0, `PTE_A_SAT0, 32'(n));
    apb(1'h0, `PTE_A_SAT0 + 8'h4, 32'(m));
    apb(1'h0, `PTE_A_MON_VAL0, 32'(n));
    apb(1'h0, `PTE_A_MON_VAL0 + 8'h4, 32'h0);
    apb(1'h1, `PTE_A_CNT_CLR, 32'h0F);
    for (int c = 1; c <= 7; c++) begin
      apb(1'h1, `PTE_A_MON_SRC0 + 8'h4, 32'(c));
      apb(1'h1, `PTE_A_CNT_CLR, 32'h20);
      pulse((c - 1) % 6, 1);
      apb(1'h0, `PTE_A_MON_VAL0 + 8'h4, 32'(c < 7));
    end
    for (int i = 0; i < 4; i++)
      apb(1'h0, `PTE_A_SAT0 + 8'(4 * i), i == 0 ? 32'h2 : 32'h1);
    $display("test counters done");
    apb(1'h1, `PTE_A_TEST_CTRL, cmdW(1'h0, 4'h1, 4'h1, 4'h0, 4'h0, 8'h01));
    apb(1'h0, `PTE_A_TEST_STAT, 32'h4);
    apb(1'h1, `PTE_A_TEST_CTRL, cmdW(1'h0, 4'h0, 4'h0, 4'h0, 4'h0, 8'h01));
    apb(1'h0, `PTE_A_TEST_STAT, 32'h4);
    for (int p = 0; p < 2; p++) begin
      pt = 4'($urandom);
      rt = 4'($urandom);
      mgmt <= p[0];
      slow <= p[0];
      apb(1'h1, `PTE_A_TEST_CTRL,
        cmdW(p[0], 4'h1, 4'h0, rt, pt, `PTE_FN_TX_PATTERN));
      apb(1'h0, `PTE_A_TEST_STAT, 32'h2);
      poke(1'h0);
      waitOn(1'h0, 1'h1);
      chk(32'(txCtrl), {23'h0, 1'h1, pt, rt});
      chk({31'h0, rxDiscard}, 32'h1);
      pulse(0, 3);
      apb(1'h0, `PTE_A_SAT0, 32'h2);
      if (p == 1) poke(1'h1);
      else apb(1'h1, `PTE_A_TEST_CTRL,
        cmdW(1'h0, 4'h1, 4'h0, 4'h0, 4'h0, `PTE_FN_STOP));
      waitOn(1'h1, 1'h1);
      waitOn(1'h1, 1'h0);
      apb(1'h0, `PTE_A_TEST_STAT, 32'h0);
    end
    slumber <= 1'h1;
    repeat (4) @(posedge clk);
    chk({30'h0, comsasAccept, comwakeAccept}, 32'h1);
    chk({31'h0, rxDiscard}, 32'h1);
    slumber <= 1'h0;
    $display("test function done");
    apb(1'h1, `PTE_A_PEAK_THR, 32'h5);
    conns(10, 10);
    apb(1'h0, `PTE_A_LAST_IDX, 32'hA);
    apb(1'h0, `PTE_A_PEAK, 32'h13);
    apb(1'h1, `PTE_A_DESC_SLOT, 32'h1);
    apb(1'h0, `PTE_A_DESC_INFO, 32'h000A002B);
    apb(1'h0, `PTE_A_DESC_VAL, 32'h13);
    conns(20, 65527);
    apb(1'h0, `PTE_A_LAST_IDX, 32'h2);
    apb(1'h1, `PTE_A_DESC_SLOT, 32'h0);
    apb(1'h0, `PTE_A_DESC_INFO, 32'h0002002B);
    chk(32'(bcasts), 32'h10001);
    apb(1'h1, `PTE_A_CNT_CLR, 32'h40);
    apb(1'h0, `PTE_A_PEAK, 32'h0);
    $display("test descriptors done");
    complete_run();
  end
endmodule
